// >>> rtl/shrp_pkg.sv
// Shared constants of the serial host register port: framing, field
// positions, register map and reset values.
// Assumes one core clock domain; every pin is synchronised by its user.
//
// Overview of operation
// - Port enabled only while port-select is low
// - Serial output tri-stated unless chip selected
// - Command word then one data word
// - MSB first: direction, nine reserved, address
// - Direction one reads, zero writes
// - Input bits sampled on serial clock rise
// - Read MSB after command fall, shift falling
// - Registers decoded by six-bit address map
// - Each register individually addressable by address
// - Port-select high gives boundary-scan, test reset
// - Reset low tri-states all outputs
package shrp_pkg;

    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    localparam int          WORD_W      = 16;
    localparam int          ADDR_W      = 6;
    localparam int          REG_COUNT   = 64;
    localparam int          CNT_W       = 6;
    localparam logic [5:0]  CNT_CMD_END = 6'h10;  // Bits 0..15 are the command
    localparam logic [5:0]  CNT_LAST    = 6'h1F;  // Last data bit
    localparam logic [5:0]  CNT_FULL    = 6'h20;  // Frame complete
    localparam int          CMD_DIR_BIT = 15;
    localparam int          CMD_ADDR_LO = 0;
    localparam logic        DIR_READ    = 1'b1;
    localparam logic [4:0]  PIN_IDLE    = 5'h1A;  // Sync reset: reset pin and select high, scan off

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [5:0]  ADDR_IO_PROC_DISABLE   = 6'h00;
    localparam logic [5:0]  ADDR_ERROR_CONDITION   = 6'h01;
    localparam logic [5:0]  ADDR_ERROR_CHECK_FLAGS = 6'h03;
    localparam logic [5:0]  ADDR_SIGNAL_STANDARD   = 6'h04;
    localparam logic [5:0]  ADDR_ANC_FILTER_FIRST  = 6'h05;
    localparam logic [5:0]  ADDR_ANC_FILTER_LAST   = 6'h09;
    localparam logic [5:0]  ADDR_PAYLOAD_FIRST     = 6'h0C;
    localparam logic [5:0]  ADDR_PAYLOAD_LAST      = 6'h0D;
    localparam logic [5:0]  ADDR_GEOMETRY_FIRST    = 6'h0E;
    localparam logic [5:0]  ADDR_GEOMETRY_LAST     = 6'h11;
    localparam logic [5:0]  ADDR_CHECKSUM_FIRST    = 6'h12;
    localparam logic [5:0]  ADDR_CHECKSUM_LAST     = 6'h19;
    localparam logic [5:0]  ADDR_ERROR_MASK        = 6'h1A;

    // Reset value of software-written registers and read value of unlisted addresses
    localparam logic [15:0] RESET_WORD             = 16'h0000;
    localparam logic [15:0] READ_UNMAPPED          = 16'h0000;

endpackage : shrp_pkg

// >>> rtl/shrp_reg_if.sv
// Carrier between the serial engine and the register file.
// Assumes both ends sit on the core clock.
interface shrp_reg_if;
    logic        wrEn;    // One-cycle write strobe
    logic [5:0]  addr;    // Address from the command word
    logic [15:0] wrData;  // Assembled write word
    logic [15:0] rdData;  // Combinational read word for addr

    modport port (output wrEn, output addr, output wrData, input rdData);
    modport regs (input wrEn, input addr, input wrData, output rdData);
endinterface : shrp_reg_if

// >>> rtl/shrp_regfile.sv
// Register file behind the serial port: writable storage and status
// read-back selected by the six-bit command address.
// Assumes status words are already in the core clock domain.
module shrp_regfile
    import shrp_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     regReset,
    shrp_reg_if.regs                      bus,
    input  wire logic [REG_COUNT-1:0][15:0] statusIn,
    output logic      [REG_COUNT-1:0][15:0] ctrlOut
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Writable registers and mixed flag word share the storage array
    function automatic logic isWritable(input logic [5:0] a);
        isWritable = (a == ADDR_IO_PROC_DISABLE) || (a == ADDR_ERROR_CHECK_FLAGS)
                  || (a >= ADDR_ANC_FILTER_FIRST && a <= ADDR_ANC_FILTER_LAST)
                  || (a >= ADDR_CHECKSUM_FIRST && a <= ADDR_CHECKSUM_LAST)
                  || (a == ADDR_ERROR_MASK);
    endfunction : isWritable

    function automatic logic isStatus(input logic [5:0] a);
        isStatus = (a == ADDR_ERROR_CONDITION) || (a == ADDR_ERROR_CHECK_FLAGS)
                || (a == ADDR_SIGNAL_STANDARD)
                || (a >= ADDR_PAYLOAD_FIRST && a <= ADDR_GEOMETRY_LAST);
    endfunction : isStatus

    logic [15:0] mem_q [REG_COUNT];
    wire         selWritable = isWritable(bus.addr);
    wire         selStatus   = isStatus(bus.addr);
    wire  [15:0] storedWord  = selWritable ? mem_q[bus.addr] : READ_UNMAPPED;
    wire  [15:0] statusWord  = selStatus ? statusIn[bus.addr] : READ_UNMAPPED;

    // Mixed word reads stored bits merged with live flags; unlisted reads zero
    assign bus.rdData = storedWord | statusWord;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Writes to unlisted or read-only addresses are dropped
    always_ff @(posedge core_clk) begin
        if (regReset) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                mem_q[i] <= RESET_WORD;
            end
        end else if (bus.wrEn && selWritable) begin
            mem_q[bus.addr] <= bus.wrData;
        end
    end

    // Control words leave as flat copies of the storage
    always_comb begin
        for (int i = 0; i < REG_COUNT; i++) begin
            ctrlOut[i] = mem_q[i];
        end
    end

endmodule : shrp_regfile

// >>> rtl/shrp_serial_port.sv
// Top of the serial host register port: pin synchronisers, frame
// engine, serial output driver, scan-mode and reset pin handling.
// Assumes a host-driven burst serial clock far slower than core_clk
// (at least eight core cycles per half period).
module shrp_serial_port
    import shrp_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic                       portSelPin,
    input  wire logic                       resetPinN,
    input  wire logic                       sclkPin,
    input  wire logic                       serialInPin,
    input  wire logic                       chipSelPinN,
    output logic                            serialOut,
    output logic                            serialOutOe,
    output logic                            scanModeEn,
    output logic                            testLogicReset,
    output logic                            outputsHighZ,
    input  wire logic [REG_COUNT-1:0][15:0] statusIn,
    output logic      [REG_COUNT-1:0][15:0] ctrlOut
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 5;

    logic [PIN_COUNT-1:0] syncA_q;
    logic [PIN_COUNT-1:0] syncB_q;
    logic                 sclkPrev_q;

    // First stage may go metastable; only the second stage reads it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            syncA_q <= PIN_IDLE;
        end else begin
            syncA_q <= {resetPinN, chipSelPinN, portSelPin, serialInPin, sclkPin};
        end
    end

    // Second stage resets to idle pins so no false select follows rst
    always_ff @(posedge core_clk) begin
        if (rst) begin
            syncB_q <= PIN_IDLE;
        end else begin
            syncB_q <= syncA_q;
        end
    end

    wire sclkSync      = syncB_q[0];
    wire serialInSync  = syncB_q[1];
    wire portSelSync   = syncB_q[2];
    wire chipSelSyncN  = syncB_q[3];
    wire resetPinSyncN = syncB_q[4];

    // Edge detector sits behind the synchroniser, never on its first stage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sclkPrev_q <= 1'b0;
        end else begin
            sclkPrev_q <= sclkSync;
        end
    end

    wire sclkRise = sclkSync & ~sclkPrev_q;
    wire sclkFall = ~sclkSync & sclkPrev_q;

    // Latency budget: a pin edge reaches the enables one to two core
    // cycles late and the output pin one cycle after that, so a read
    // bit appears some 20 to 30 ns after the host's falling edge. The
    // host samples half a period later; a half period shorter than
    // about three core cycles would lose the first read bit. A faster
    // core clock widens that margin, a slower one eats into it.

    // ------------------------------------------------------------
    // Mode and reset decode
    // ------------------------------------------------------------
    // Device reset pin clears the register file as well as the core reset
    // Reset pin also gates select, so the output falls quiet in reset
    wire pinInReset = ~resetPinSyncN;
    wire regReset   = rst | pinInReset;
    wire hostMode   = ~portSelSync;
    wire selected   = hostMode & ~chipSelSyncN & ~pinInReset;

    // ------------------------------------------------------------
    // Frame engine state
    // ------------------------------------------------------------
    logic [CNT_W-1:0]  bitCnt_q;
    logic [CNT_W-1:0]  bitCnt_d;
    logic [WORD_W-1:0] cmd_q;
    logic [WORD_W-1:0] cmd_d;
    logic [WORD_W-1:0] wrShift_q;
    logic [WORD_W-1:0] wrShift_d;
    logic [WORD_W-1:0] outShift_q;
    logic [WORD_W-1:0] outShift_d;

    // Carrier to the register file; read word is combinational on addr
    shrp_reg_if regBus ();

    // Phase decode of the current bit count
    wire inCommand  = (bitCnt_q < CNT_CMD_END);
    wire inData     = ~inCommand & (bitCnt_q < CNT_FULL);
    wire isRead     = (cmd_q[CMD_DIR_BIT] == DIR_READ);
    wire takeBit    = selected & sclkRise & (bitCnt_q < CNT_FULL);
    wire lastBit    = (bitCnt_q == CNT_LAST);
    wire cmdDone    = (bitCnt_q == CNT_CMD_END);
    wire loadRead   = selected & sclkFall & cmdDone & isRead;
    wire shiftRead  = selected & sclkFall & inData & ~cmdDone & isRead;

    // Count advances on each sampled bit; extra clocks past a frame are ignored
    always_comb begin
        bitCnt_d = bitCnt_q;
        if (!selected) begin
            bitCnt_d = '0;
        end else if (takeBit) begin
            bitCnt_d = bitCnt_q + 6'h01;
        end
    end

    // Command word shifts in MSB first during the first sixteen bits
    always_comb begin
        cmd_d = cmd_q;
        if (!selected) begin
            cmd_d = '0;
        end else if (takeBit && inCommand) begin
            cmd_d = {cmd_q[WORD_W-2:0], serialInSync};
        end
    end

    // Write data shifts in only when the direction asks for a write
    always_comb begin
        wrShift_d = wrShift_q;
        if (!selected) begin
            wrShift_d = '0;
        end else if (takeBit && inData && !isRead) begin
            wrShift_d = {wrShift_q[WORD_W-2:0], serialInSync};
        end
    end

    // Read word loads at the fall closing the command, then shifts on falls
    always_comb begin
        outShift_d = outShift_q;
        if (!selected) begin
            outShift_d = '0;
        end else if (loadRead) begin
            outShift_d = regBus.rdData;
        end else if (shiftRead) begin
            outShift_d = {outShift_q[WORD_W-2:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Frame engine registers
    // ------------------------------------------------------------
    // Count and command clear together so a new frame starts clean
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bitCnt_q <= '0;
            cmd_q    <= '0;
        end else begin
            bitCnt_q <= bitCnt_d;
            cmd_q    <= cmd_d;
        end
    end

    // Data shifters; the read shifter also feeds the output pin
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrShift_q  <= '0;
            outShift_q <= '0;
        end else begin
            wrShift_q  <= wrShift_d;
            outShift_q <= outShift_d;
        end
    end

    // ------------------------------------------------------------
    // Register file access
    // ------------------------------------------------------------
    // Reserved bits 14..6 never reach the decoder
    assign regBus.addr   = cmd_q[CMD_ADDR_LO +: ADDR_W];
    // Write commits on the rise of the last data bit, assembled on the fly
    assign regBus.wrEn   = takeBit & lastBit & !isRead;
    assign regBus.wrData = {wrShift_q[WORD_W-2:0], serialInSync};

    // Same clock on both sides, so no crossing between engine and storage
    shrp_regfile u_regfile (
        .core_clk (core_clk),
        .regReset (regReset),
        .bus      (regBus),
        .statusIn (statusIn),
        .ctrlOut  (ctrlOut)
    );

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Output bit and enable are registered to keep the pin glitch free;
    // the enable follows chip select so shared lines never collide
    always_ff @(posedge core_clk) begin
        if (rst) begin
            serialOut   <= 1'b0;
            serialOutOe <= 1'b0;
        end else begin
            serialOut   <= outShift_d[WORD_W-1];
            serialOutOe <= selected;
        end
    end

    // Mode flags only; the scan port itself lives outside this block,
    // so its enable, test reset and the high-z flag are all that is produced here
    always_ff @(posedge core_clk) begin
        if (rst) begin
            scanModeEn     <= 1'b0;
            testLogicReset <= 1'b0;
            outputsHighZ   <= 1'b1;
        end else begin
            scanModeEn     <= portSelSync & ~pinInReset;
            testLogicReset <= portSelSync & pinInReset;
            outputsHighZ   <= pinInReset;
        end
    end

endmodule : shrp_serial_port

// >>> verification/shrp_port_properties.sv
// Pin-level properties of the serial register port.
// Assumes a bind onto shrp_serial_port and a host keeping sclk slow.
module shrp_port_checker
    import shrp_pkg::*;
(
    input wire logic                       core_clk,
    input wire logic                       rst,
    input wire logic                       portSelPin,
    input wire logic                       resetPinN,
    input wire logic                       sclkPin,
    input wire logic                       chipSelPinN,
    input wire logic                       serialOut,
    input wire logic                       serialOutOe,
    input wire logic                       scanModeEn,
    input wire logic                       testLogicReset,
    input wire logic                       outputsHighZ,
    input wire logic [REG_COUNT-1:0][15:0] ctrlOut
);
    // ------------
    // Properties
    // ------------
    // Five cycles cover the two-flop sync plus the output register
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence s_csIdle; chipSelPinN [*5]; endsequence
    sequence s_scan; (portSelPin && resetPinN) [*5]; endsequence
    sequence s_trst; (portSelPin && !resetPinN) [*5]; endsequence
    sequence s_pinRst; (!resetPinN) [*5]; endsequence
    property p_oeCs; s_csIdle |-> !serialOutOe; endproperty
    a_oeCs: assert property (p_oeCs) else $error("driving while deselected");
    property p_oeMode; portSelPin [*5] |-> !serialOutOe; endproperty
    a_oeMode: assert property (p_oeMode) else $error("driving in scan mode");
    property p_scan; s_scan |-> scanModeEn && !testLogicReset; endproperty
    a_scan: assert property (p_scan) else $error("scan mode flag wrong");
    property p_trst; s_trst |-> testLogicReset && !scanModeEn; endproperty
    a_trst: assert property (p_trst) else $error("test reset flag wrong");
    property p_hiZ; s_pinRst |-> outputsHighZ && !serialOutOe; endproperty
    a_hiZ: assert property (p_hiZ) else $error("outputs live in reset");
    property p_noHiZ; resetPinN [*5] |-> !outputsHighZ; endproperty
    a_noHiZ: assert property (p_noHiZ) else $error("high-z without reset");
    property p_drop; $rose(chipSelPinN) |-> ##[1:5] !serialOutOe; endproperty
    a_drop: assert property (p_drop) else $error("enable held after deselect");
    // Serial output may only move in the low half of sclk
    property p_fall;
        $changed(serialOut) && serialOutOe && $past(serialOutOe) |-> !sclkPin && !$past(sclkPin, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("output moved off a falling edge");
    property p_idle; (chipSelPinN && resetPinN) [*6] |-> $stable(ctrlOut); endproperty
    a_idle: assert property (p_idle) else $error("register moved outside a frame");
    property p_inert; ctrlOut[1] == 16'h0000 && ctrlOut[63] == 16'h0000; endproperty
    a_inert: assert property (p_inert) else $error("storage behind read-only address");
endmodule : shrp_port_checker

bind shrp_serial_port shrp_port_checker i_chk (.core_clk(core_clk), .rst(rst), .portSelPin(portSelPin),
    .resetPinN(resetPinN), .sclkPin(sclkPin), .chipSelPinN(chipSelPinN), .serialOut(serialOut),
    .serialOutOe(serialOutOe), .scanModeEn(scanModeEn), .testLogicReset(testLogicReset),
    .outputsHighZ(outputsHighZ), .ctrlOut(ctrlOut));

// >>> verification/shrp_host_model.sv
// Host processor model: frames register accesses on the serial pins.
// Assumes the caller spaces accesses; sclk stands low between frames.
module shrp_host_model (
    output logic      sclk,
    output logic      sdi,
    output logic      csN,
    input  wire logic sdo,
    input  wire logic sdoOe
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
        csN = 1'b1;
    end
    // Equal halves of at least 80 ns; short nBits aborts the frame
    task automatic access(input logic [15:0] cmd, input logic [15:0] wrWord, input int halfNs,
                          input int nBits, output logic [15:0] rdWord);
        logic [31:0] frame;
        frame = {cmd, wrWord};
        rdWord = 16'h0000;
        csN = 1'b0;
        #(halfNs);
        for (int i = 0; i < nBits; i++) begin
            sdi = frame[31 - i];
            #(halfNs);
            sclk = 1'b1;
            if (i >= 16) rdWord = {rdWord[14:0], sdoOe ? sdo : 1'bx};
            #(halfNs);
            sclk = 1'b0;
        end
        sdi = ~sdi; // Released line must not echo the last bit
        #(halfNs);
        csN = 1'b1;
        #(halfNs);
    endtask : access
endmodule : shrp_host_model

// >>> verification/shrp_serial_port_tb_top.sv
// Self-checking bench: random and corner accesses through the host
// model, then scan mode and reset pin. Assumes a lone DUT on core_clk.
module shrp_serial_port_tb_top
    import shrp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic                       core_clk, rst, portSelPin, resetPinN, sclkPin, serialInPin, chipSelPinN;
    logic                       serialOut, serialOutOe, scanModeEn, testLogicReset, outputsHighZ;
    logic [REG_COUNT-1:0][15:0] statusIn, ctrlOut;
    logic [15:0]                mirror [REG_COUNT];
    logic [15:0]                seed, rd;
    logic [5:0]                 addr;
    logic [5:0]                 corner [6] = '{6'h00, 6'h1A, 6'h3F, 6'h01, 6'h03, 6'h19};
    int                         numErrors, compares;

    shrp_serial_port i_dut (.core_clk(core_clk), .rst(rst), .portSelPin(portSelPin), .resetPinN(resetPinN),
        .sclkPin(sclkPin), .serialInPin(serialInPin), .chipSelPinN(chipSelPinN), .serialOut(serialOut),
        .serialOutOe(serialOutOe), .scanModeEn(scanModeEn), .testLogicReset(testLogicReset),
        .outputsHighZ(outputsHighZ), .statusIn(statusIn), .ctrlOut(ctrlOut));
    shrp_host_model i_host (.sclk(sclkPin), .sdi(serialInPin), .csN(chipSelPinN), .sdo(serialOut),
        .sdoOe(serialOutOe));

    // ------------
    // Helpers
    // ------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic isWr(input logic [5:0] a);
        return a == 6'h00 || a == 6'h03 || (a >= 6'h05 && a <= 6'h09) || (a >= 6'h12 && a <= 6'h1A);
    endfunction : isWr
    function automatic logic [15:0] expRead(input logic [5:0] a);
        logic st;
        st = a == 6'h01 || a == 6'h03 || a == 6'h04 || (a >= 6'h0C && a <= 6'h11);
        return (isWr(a) ? mirror[a] : 16'h0000) | (st ? statusIn[a] : 16'h0000);
    endfunction : expRead
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic checkWord(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : checkWord
    task automatic checkBit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : checkBit
    // Reserved command bits carry random junk on purpose
    task automatic doWrite(input logic [5:0] a, input logic [15:0] d, input int half, input int nBits);
        logic [15:0] unused;
        i_host.access({1'b0, seed[8:0], a}, d, half, nBits, unused);
        if (nBits == 32 && isWr(a)) mirror[a] = d;
    endtask : doWrite
    task automatic doRead(input logic [5:0] a, input int half);
        logic [15:0] got;
        i_host.access({1'b1, ~seed[8:0], a}, seed, half, 32, got);
        checkWord("read word", expRead(a), got);
    endtask : doRead
    task automatic giveVerdict();
        $display("Comparisons %0d, mismatches %0d", compares, numErrors);
        if (numErrors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : giveVerdict

    // ------------
    // Stimulus
    // ------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Whole run is near 70k cycles
    initial begin
        #1_000_000;
        numErrors++;
        giveVerdict();
    end
    initial begin
        rst = 1'b1;
        portSelPin = 1'b0;
        resetPinN = 1'b1;
        statusIn = '0;
        seed = 16'h005B;
        foreach (mirror[i]) mirror[i] = RESET_WORD;
        tick(4);
        rst = 1'b0;
        for (int i = 0; i < REG_COUNT; i++) begin
            seed = lfsr(seed);
            statusIn[i] = seed;
        end
        tick(4);
        checkBit("high-z flag", 1'b0, outputsHighZ);
        for (int a = 0; a < 32; a++) doRead(6'(a), 80);
        for (int i = 0; i < 30; i++) begin
            seed = lfsr(seed);
            addr = (i < 6) ? corner[i] : seed[5:0];
            doWrite(addr, lfsr(seed), seed[15] ? 160 : 80, 32);
            tick(2);
            checkWord("stored word", isWr(addr) ? mirror[addr] : 16'h0000, ctrlOut[addr]);
            doRead(addr, seed[14] ? 160 : 80);
        end
        doWrite(6'h05, 16'hA5C3, 80, 20);
        tick(2);
        checkWord("aborted write", mirror[5], ctrlOut[5]);
        doRead(6'h05, 80);
        portSelPin = 1'b1;
        tick(5);
        checkBit("scan enable", 1'b1, scanModeEn);
        i_host.access(16'h001A, ~mirror[26], 80, 32, rd);
        checkWord("scan-mode write", mirror[26], ctrlOut[26]);
        // Held far below the device's 1 ms minimum; the logic needs only the sync delay
        resetPinN = 1'b0;
        tick(5);
        checkBit("test reset", 1'b1, testLogicReset);
        foreach (mirror[i]) mirror[i] = RESET_WORD;
        portSelPin = 1'b0;
        tick(5);
        checkBit("high-z flag", 1'b1, outputsHighZ);
        checkWord("cleared word", RESET_WORD, ctrlOut[26]);
        resetPinN = 1'b1;
        tick(5);
        doRead(6'h1A, 80);
        giveVerdict();
    end
endmodule : shrp_serial_port_tb_top
